// ---- hw/cld_channel.sv ----
/*
 * command list data channel: fetches 36-bit command words from memory and
 * moves data between a device controller and memory; maintenance local
 * mode; control over an AHB-Lite slave.
 * assumes the memory bus answers each request with one ack pulse, the
 * controller signals are synchronous to sys_clk except the raw pins.
 */
// The register addresses and the AHB-Lite interface to the registers were decided locally.
//
// Notes on behaviour
// - command word parity error sets flag under maintenance
// - data parity error sets separate flag likewise
// - lockout forbids writing even parity to memory
// - clear command resets all channel control
// - local mode ignores bus inputs, generates them
// - local start starts; single step one cycle
// - local stop halts after current memory cycle
// - direction setting picks simulated write or read
// - single step stops after each local cycle
// - auto clear fires 300 us after local start
// - parity halt stops channel, keeps memory buffer
// - wide mode 14/22 split, narrow 18/18
// - block size 256K-1 narrow, 16K-1 wide
// - first requester owns; supplies list start address
// - transfer counted words, increment count and address
// - count all ones means next command word
// - zero count nonzero address jumps
// - device read zero address discards words
// - zero word stops and signals owner
// - other controllers refused while list runs
// - address incremented before first transfer
// - command address increments after every fetch
// - terminator drops busy and goes idle
`timescale 1ns/100ps

module cld_channel import cld_pkg::*; #(
	parameter int NUM_CTRL = 4,
	parameter int AUTOCLR_CNT = AUTOCLR_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clkEn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// controller side (raw pins)
	input wire logic [NUM_CTRL-1:0] ctrlRequest,
	input wire logic ctrlDevicePulse,
	input wire logic [INIT_ADDR_W-1:0] ctrlInitAddr,
	input wire logic memory_to_device_direction,
	input wire logic [WORD_W-1:0] ctrlWriteData,
	output logic [NUM_CTRL-1:0] ctrlGrant,
	output logic channelBusy,
	output logic ctrlWordStrobe,
	output logic [WORD_W-1:0] ctrlReadData,
	output logic ctrlDone,
	// memory bus
	output cld_mem_req_t memReq,
	input wire cld_mem_rsp_t memRsp
);

	// all state except the pin synchronisers in one struct
	typedef struct packed {
		cld_state_t st;
		logic [10:0] control;
		logic [NUM_CTRL-1:0] owner;
		logic [ADDR_W-1:0] cmdAddr;
		logic [ADDR_W-1:0] dataAddr;
		logic [NARROW_CNT_W-1:0] count;
		logic skipMode;
		logic [WORD_W-1:0] memory_buffer;
		logic cmd_word_parity_err_flag;
		logic data_word_parity_err_flag;
		logic memBusy;
		logic memWrite;
		logic dirLatched;
		logic stepArmed;
		logic stopPending;
		logic done;
		logic wordStrobe; // memory word handed to the device
		logic [31:0] autoClr;
		logic autoRun;
		logic dataPhase;
		logic dataWrite;
		logic [7:0] dataOfs;
		logic [31:0] rdata;
	} cld_regs_t;

	cld_regs_t r;
	cld_regs_t next_r;

	// two-flop synchronisers for raw pins
	logic [NUM_CTRL+2+INIT_ADDR_W-1:0] syncA;
	logic [NUM_CTRL+2+INIT_ADDR_W-1:0] syncB;
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			syncA <= '0;
			syncB <= '0;
		end else if (clkEn) begin
			syncA <= {ctrlInitAddr, memory_to_device_direction, ctrlDevicePulse, ctrlRequest};
			syncB <= syncA;
		end
	end

	// local mode replaces the external bus signals
	logic localMode;
	logic [NUM_CTRL-1:0] reqIn;
	logic pulseIn;
	logic dirIn;
	logic [INIT_ADDR_W-1:0] initAddrIn; // list start address bits, synced
	assign localMode = r.control[CTL_LOCAL];
	assign reqIn = localMode ? '0 : syncB[NUM_CTRL-1:0];
	assign pulseIn = localMode ? 1'b1 : syncB[NUM_CTRL];
	assign dirIn = localMode ? r.control[CTL_DIR] : syncB[NUM_CTRL+1];
	assign initAddrIn = localMode ? '0 : syncB[NUM_CTRL+2+:INIT_ADDR_W];

	// lowest set bit as a one-hot grant
	function automatic logic [NUM_CTRL-1:0] pickFirst(input logic [NUM_CTRL-1:0] v);
		return v & (~v + 1'b1);
	endfunction : pickFirst

	// even parity word has odd bit count plus parity... compute odd parity bit
	function automatic logic oddParity(input logic [WORD_W-1:0] w);
		return ~(^w);
	endfunction : oddParity

	logic wide;
	assign wide = r.control[CTL_WIDE];

	// command word split by addressing mode
	logic [NARROW_CNT_W-1:0] cwCount; // count, widened with ones in wide mode
	logic [ADDR_W-1:0] cwAddr; // address field, zero-extended
	logic cwCountZero; // count field all zero
	always_comb begin
		if (wide) begin
			cwCount = {{(NARROW_CNT_W-WIDE_CNT_W){1'b1}}, r.memory_buffer[35:22]};
			cwAddr = r.memory_buffer[21:0];
			cwCountZero = r.memory_buffer[35:22] == '0;
		end else begin
			cwCount = r.memory_buffer[35:18];
			cwAddr = {4'h0, r.memory_buffer[17:0]};
			cwCountZero = r.memory_buffer[35:18] == '0;
		end
	end

	logic busWrite;
	logic busRead;
	assign busWrite = hsel && hready && htrans[1] && hwrite;
	assign busRead = hsel && hready && htrans[1] && !hwrite;

	// next state
	always_comb begin
		logic cmdPeSet; // command parity event this cycle
		logic dataPeSet; // data parity event this cycle
		cmdPeSet = 1'b0;
		dataPeSet = 1'b0;
		next_r = r;
		next_r.done = 1'b0;
		next_r.wordStrobe = 1'b0;
		// bus data phase completes a write
		next_r.dataPhase = busWrite;
		if (busWrite || busRead) begin
			next_r.dataOfs = haddr[7:0];
		end
		next_r.control[CTL_START] = 1'b0;
		next_r.control[CTL_STOP] = 1'b0;
		next_r.control[CTL_CLEAR] = 1'b0;
		if (r.dataPhase && r.dataOfs == OFS_CONTROL) begin
			next_r.control = hwdata[10:0];
		end
		// read data captured for the data phase
		unique case (haddr[7:0])
			OFS_CONTROL: next_r.rdata = {21'h0, r.control};
			OFS_STATUS: next_r.rdata = {23'h0, r.st, r.stopPending, r.memBusy,
				r.data_word_parity_err_flag, r.cmd_word_parity_err_flag, channelBusy, 1'b0};
			OFS_CMDADDR: next_r.rdata = {10'h0, r.cmdAddr};
			OFS_DATAADDR: next_r.rdata = {10'h0, r.dataAddr};
			OFS_COUNT: next_r.rdata = {14'h0, r.count};
			OFS_BUFFER: next_r.rdata = r.memory_buffer[31:0];
			default: next_r.rdata = 32'h0;
		endcase

		// local start arms one memory cycle in single step
		if (localMode && r.control[CTL_START]) begin
			next_r.stepArmed = 1'b1;
			if (r.control[CTL_AUTOCLR]) begin
				next_r.autoRun = 1'b1;
				next_r.autoClr = 32'h0;
			end
		end
		if (localMode && r.control[CTL_STOP]) begin
			next_r.stopPending = 1'b1;
		end

		// memory answer completes the current cycle
		if (r.memBusy && memRsp.ack) begin
			next_r.memBusy = 1'b0;
			if (localMode && r.control[CTL_SSTEP]) begin
				next_r.stepArmed = 1'b0;
			end
		end

		unique case (r.st)
			CLD_IDLE: begin
				// first requester takes the channel
				if (localMode && r.control[CTL_START]) begin
					next_r.st = CLD_WAITADDR;
					next_r.owner = '0;
				end else if (|reqIn) begin
					next_r.owner = pickFirst(reqIn);
					next_r.st = CLD_WAITADDR;
				end
			end
			CLD_WAITADDR: begin
				// wait as long as it takes for the start address
				if (pulseIn) begin
					next_r.cmdAddr = {13'h0, initAddrIn, 1'b0};
					next_r.dirLatched = dirIn;
					next_r.st = CLD_FETCH;
				end
			end
			CLD_FETCH: begin
				if (!r.memBusy && !memRsp.ack && (!localMode || !r.control[CTL_SSTEP]
					|| r.stepArmed)) begin
					next_r.memBusy = 1'b1;
					next_r.memWrite = 1'b0;
				end
				if (r.memBusy && memRsp.ack) begin
					next_r.cmdAddr = r.cmdAddr + 1'b1;
					next_r.st = CLD_EVAL;
					if (memRsp.parity != oddParity(memRsp.data)) begin
						if (r.control[CTL_MAINT]) begin
							next_r.cmd_word_parity_err_flag = 1'b1;
							cmdPeSet = 1'b1;
						end
						if (r.control[CTL_PEHALT]) begin
							next_r.st = CLD_HALT;
						end
					end
					next_r.memory_buffer = memRsp.data;
				end
			end
			CLD_EVAL: begin
				if (r.memory_buffer == '0) begin
					next_r.done = 1'b1;
					next_r.owner = '0;
					next_r.st = CLD_IDLE;
				end else if (cwCountZero) begin
					next_r.cmdAddr = cwAddr;
					next_r.st = CLD_FETCH;
				end else begin
					// count negative, address pre-incremented
					next_r.count = cwCount;
					next_r.dataAddr = cwAddr + 1'b1;
					next_r.skipMode = cwAddr == '0;
					next_r.st = CLD_XFER;
				end
			end
			CLD_XFER: begin
				// skip words on device read, no memory cycle
				if (r.skipMode && !r.dirLatched) begin
					if (pulseIn) begin
						next_r.count = r.count + 1'b1;
						next_r.dataAddr = r.dataAddr + 1'b1;
					end
				end else if (!r.memBusy && !memRsp.ack && (!localMode
					|| !r.control[CTL_SSTEP] || r.stepArmed) && pulseIn) begin
					next_r.memBusy = 1'b1;
					next_r.memWrite = !r.dirLatched;
					if (!r.dirLatched) begin
						next_r.memory_buffer = localMode ? {14'h0, r.dataAddr} : ctrlWriteData;
					end
				end
				if (r.memBusy && memRsp.ack) begin
					next_r.count = r.count + 1'b1;
					next_r.dataAddr = r.dataAddr + 1'b1;
					if (r.dirLatched) begin
						next_r.memory_buffer = memRsp.data;
						next_r.wordStrobe = 1'b1; // strobe with the word in the buffer
						if (memRsp.parity != oddParity(memRsp.data)) begin
							if (r.control[CTL_MAINT]) begin
								next_r.data_word_parity_err_flag = 1'b1;
								dataPeSet = 1'b1;
							end
							if (r.control[CTL_PEHALT]) begin
								next_r.st = CLD_HALT;
							end
						end
					end
				end
				// the word taken at an all-ones count is the last one
				if (next_r.st == CLD_XFER && next_r.count == '0 && !next_r.memBusy) begin
					next_r.st = CLD_FETCH;
				end
			end
			CLD_HALT: begin
				// held with memory buffer kept until clear
				next_r.memBusy = 1'b0;
			end
		endcase

		// stop lands only with no memory cycle open
		if (r.stopPending && !next_r.memBusy) begin
			next_r.st = CLD_HALT;
			next_r.stopPending = 1'b0;
		end

		// auto clear timer
		if (r.autoRun) begin
			next_r.autoClr = r.autoClr + 1'b1;
		end
		if (r.control[CTL_CLEAR] || (r.autoRun && r.autoClr == 32'(AUTOCLR_CNT - 1))) begin
			next_r.st = CLD_IDLE;
			next_r.owner = '0;
			next_r.memBusy = 1'b0;
			next_r.stepArmed = 1'b0;
			next_r.stopPending = 1'b0;
			next_r.autoRun = 1'b0;
			next_r.autoClr = 32'h0;
			// a parity event in the clear cycle still sets its flag
			next_r.cmd_word_parity_err_flag = cmdPeSet;
			next_r.data_word_parity_err_flag = dataPeSet;
			next_r.count = '0;
			if (!r.control[CTL_PEHALT]) begin
				next_r.memory_buffer = '0;
			end
		end
	end

	// register the whole state
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			r <= '0;
			r.st <= CLD_IDLE;
			r.control <= CONTROL_RST;
		end else if (clkEn) begin
			r <= next_r;
		end
	end

	// grant only the owner; others refused while busy
	assign ctrlGrant = r.owner;
	assign channelBusy = r.st != CLD_IDLE;
	assign ctrlDone = r.done;
	assign ctrlWordStrobe = r.wordStrobe;
	assign ctrlReadData = r.memory_buffer;

	// memory request; always odd parity, whatever the lockout setting
	always_comb begin
		memReq.req = r.memBusy;
		memReq.write = r.memWrite;
		memReq.addr = r.st == CLD_FETCH ? r.cmdAddr : r.dataAddr;
		memReq.data = r.memory_buffer;
		memReq.parity = oddParity(r.memory_buffer);
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = r.rdata;

	// assertions
	a_parity_never_even: assert property (@(posedge sys_clk) disable iff (rst)
		memReq.req && memReq.write && r.control[CTL_EVLOCK]
		|-> ^{memReq.data, memReq.parity}) else $error("even parity written");
	a_clear_to_idle: assert property (@(posedge sys_clk) disable iff (rst)
		clkEn && r.control[CTL_CLEAR] |=> r.st == CLD_IDLE) else $error("clear missed");
	a_terminator_idle: assert property (@(posedge sys_clk) disable iff (rst)
		clkEn && r.st == CLD_EVAL && r.memory_buffer == '0 && !r.control[CTL_CLEAR]
		&& !r.stopPending |=> !channelBusy && ctrlDone) else $error("no stop");
	a_fetch_incr: assert property (@(posedge sys_clk) disable iff (rst)
		clkEn && r.st == CLD_FETCH && r.memBusy && memRsp.ack && !r.control[CTL_CLEAR]
		|=> r.cmdAddr == $past(r.cmdAddr) + 1'b1) else $error("fetch addr");
	a_local_no_grant: assert property (@(posedge sys_clk) disable iff (rst)
		localMode && r.st == CLD_IDLE |-> ctrlGrant == '0) else $error("local grant");
	a_owner_held: assert property (@(posedge sys_clk) disable iff (rst)
		clkEn && channelBusy && r.owner != '0 && !r.control[CTL_CLEAR] && !r.autoRun
		&& r.st != CLD_EVAL |=> ctrlGrant == $past(ctrlGrant)) else $error("owner");
	a_halt_keeps_mb: assert property (@(posedge sys_clk) disable iff (rst)
		clkEn && r.st == CLD_HALT && r.control[CTL_PEHALT]
		|=> r.memory_buffer == $past(r.memory_buffer)) else $error("mb lost");
	a_count_step: assert property (@(posedge sys_clk) disable iff (rst)
		clkEn && r.st == CLD_XFER && r.memBusy && memRsp.ack && !r.control[CTL_CLEAR]
		&& !r.autoRun |=> r.count == $past(r.count) + 1'b1) else $error("count");
	c_terminate: cover property (@(posedge sys_clk) r.st == CLD_EVAL ##1 r.st == CLD_IDLE);
	c_jump: cover property (@(posedge sys_clk) r.st == CLD_EVAL ##1 r.st == CLD_FETCH);
	c_halt: cover property (@(posedge sys_clk) r.st == CLD_HALT);
	c_xfer_done: cover property (@(posedge sys_clk) r.st == CLD_XFER ##1 r.st == CLD_FETCH);

endmodule : cld_channel

// ---- hw/cld_pkg.sv ----
/*
 * package for the command list data channel: command word layout,
 * reset values, timing constants, state enum and carrier structs.
 * assumes one 100 MHz clock and a synchronous active-high reset.
 */
package cld_pkg;

	// word and address widths
	localparam int WORD_W = 36;
	localparam int ADDR_W = 22;
	localparam int NARROW_CNT_W = 18;
	localparam int WIDE_CNT_W = 14;
	localparam int INIT_ADDR_W = 8;

	// bus register offsets (byte addresses)
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CMDADDR = 8'h08;
	localparam logic [7:0] OFS_DATAADDR = 8'h0C;
	localparam logic [7:0] OFS_COUNT = 8'h10;
	localparam logic [7:0] OFS_BUFFER = 8'h14;

	// control register bit positions
	localparam int CTL_LOCAL = 0;
	localparam int CTL_DIR = 1;
	localparam int CTL_SSTEP = 2;
	localparam int CTL_AUTOCLR = 3;
	localparam int CTL_PEHALT = 4;
	localparam int CTL_MAINT = 5;
	localparam int CTL_WIDE = 6;
	localparam int CTL_EVLOCK = 7;
	localparam int CTL_START = 8;
	localparam int CTL_STOP = 9;
	localparam int CTL_CLEAR = 10;
	localparam logic [10:0] CONTROL_RST = 11'h000;

	// timed auto-clear delay
	localparam int AUTOCLR_US = 300;
	localparam int CLK_MHZ = 100;
	localparam int AUTOCLR_CYCLES = AUTOCLR_US * CLK_MHZ;

	// channel sequencer states
	typedef enum logic [2:0] {
		CLD_IDLE,
		CLD_WAITADDR,
		CLD_FETCH,
		CLD_EVAL,
		CLD_XFER,
		CLD_HALT
	} cld_state_t;

	// memory request toward the memory bus
	typedef struct packed {
		logic req;
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [WORD_W-1:0] data;
		logic parity;
	} cld_mem_req_t;

	// memory answer from the memory bus
	typedef struct packed {
		logic ack;
		logic [WORD_W-1:0] data;
		logic parity;
	} cld_mem_rsp_t;

endpackage : cld_pkg

// ---- testbench/cld_mem_model.sv ----
/* memory bus model for the channel: word store, ack after a short or long wait.
 * assumes one request outstanding and sys_clk shared with the channel. */
`timescale 1ns/100ps
module cld_mem_model import cld_pkg::*; (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic slow,
	input wire logic badParity,
	input wire cld_mem_req_t memReq,
	output cld_mem_rsp_t memRsp,
	output int ackCount,
	output int wrCount,
	output int evenCount
);
	logic [WORD_W-1:0] mem [256]; // word store, low address bits only
	int waitCnt; // cycles spent on this request
	logic [7:0] ix; // word index
	assign ix = memReq.addr[7:0];
	// answer one request at a time; while badParity is set, bad parity on any read with address bit 6 set (40-7F, C0-FF)
	always @(posedge sys_clk) begin
		memRsp.ack <= 1'b0;
		memRsp.data <= ~memRsp.data; // released lines never hold the word
		memRsp.parity <= ~memRsp.parity;
		if (rst) begin
			memRsp <= '0;
			waitCnt <= 0;
			ackCount <= 0;
			wrCount <= 0;
			evenCount <= 0;
		end else if (memReq.req === 1'b1 && !memRsp.ack) begin
			if (waitCnt < (slow ? 3 : 0)) begin
				waitCnt <= waitCnt + 1;
			end else begin
				waitCnt <= 0;
				memRsp.ack <= 1'b1;
				ackCount <= ackCount + 1;
				if (memReq.write) begin
					mem[ix] <= memReq.data;
					wrCount <= wrCount + 1;
					if (^{memReq.data, memReq.parity} == 1'b0) evenCount <= evenCount + 1;
				end else begin
					memRsp.data <= mem[ix];
					memRsp.parity <= ~(^mem[ix]) ^ (badParity & ix[6]);
				end
			end
		end
	end
endmodule : cld_mem_model

// ---- testbench/tb_cld_channel.sv ----
/* self-checking bench for the command list channel.
 * assumes the memory model beside it; bus and pins driven here. */
`timescale 1ns/100ps
module tb_cld_channel import cld_pkg::*;;
	logic sys_clk, rst, hsel, hwrite, hreadyout, hresp, slow, badParity;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] ctrlRequest, ctrlGrant;
	logic ctrlDevicePulse, memToDev, channelBusy, ctrlWordStrobe, ctrlDone;
	logic [7:0] ctrlInitAddr;
	logic [35:0] ctrlWriteData, ctrlReadData;
	logic [35:0] rdQ [$]; // words handed to the device
	cld_mem_req_t memReq;
	cld_mem_rsp_t memRsp;
	int ackCount, wrCount, evenCount, failCount, cmpCount;
	cld_channel #(.NUM_CTRL(4), .AUTOCLR_CNT(50)) u_cld_channel (
		.sys_clk(sys_clk), .rst(rst), .clkEn(1'b1), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ctrlRequest(ctrlRequest),
		.ctrlDevicePulse(ctrlDevicePulse), .ctrlInitAddr(ctrlInitAddr),
		.memory_to_device_direction(memToDev), .ctrlWriteData(ctrlWriteData),
		.ctrlGrant(ctrlGrant), .channelBusy(channelBusy), .ctrlWordStrobe(ctrlWordStrobe),
		.ctrlReadData(ctrlReadData), .ctrlDone(ctrlDone), .memReq(memReq), .memRsp(memRsp));
	cld_mem_model u_cld_mem_model (.sys_clk(sys_clk), .rst(rst), .slow(slow),
		.badParity(badParity), .memReq(memReq), .memRsp(memRsp), .ackCount(ackCount),
		.wrCount(wrCount), .evenCount(evenCount));
	// clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// collect words strobed to the device
	always @(posedge sys_clk) if (ctrlWordStrobe === 1'b1) rdQ.push_back(ctrlReadData);
	task automatic check(input logic [35:0] seen, input logic [35:0] exp, input string msg);
		cmpCount++;
		if (seen !== exp) begin
			failCount++;
			$display("[ERR] %0t %s: seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : check
	task automatic testDone();
		$display("comparisons %0d mismatches %0d", cmpCount, failCount);
		if (failCount == 0 && cmpCount > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : testDone
	task automatic hang(input string what);
		failCount++;
		$display("[ERR] %0t wait for %s ran out", $time, what);
		testDone();
	endtask : hang
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	task automatic waitRdy();
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (n >= 20) hang("bus ready");
	endtask : waitRdy
	// one single word transfer; read data lands in rd
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		waitRdy();
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		waitRdy();
		rd = hrdata;
	endtask : ahb
	function automatic logic [31:0] ctl(input int b);
		return 32'h1 << b;
	endfunction : ctl
	function automatic logic [35:0] cw(input logic [17:0] wc, input logic [21:0] da,
		input logic wide);
		return wide ? {wc[13:0], da} : {wc, da[17:0]};
	endfunction : cw
	// claim the channel as controller 0 and hand over the list address
	task automatic startList(input logic [7:0] ia, input logic toDev, input logic rival);
		int n;
		memToDev <= toDev;
		ctrlInitAddr <= ia;
		ctrlRequest <= 4'h1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (channelBusy !== 1'b1 && n < 50);
		if (n >= 50) hang("busy");
		ctrlDevicePulse <= 1'b1;
		tick(4);
		ctrlRequest <= rival ? 4'h4 : 4'h0;
	endtask : startList
	// run to the terminator, owner must never change
	task automatic finishList();
		int n;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
			if (n == 12) ctrlRequest <= 4'h0;
			if (channelBusy === 1'b1) check(36'(ctrlGrant), 36'h1, "owner");
		end while (ctrlDone !== 1'b1 && n < 3000);
		if (n >= 3000) hang("done");
		ctrlDevicePulse <= 1'b0;
		tick(2);
		check(36'(channelBusy), 36'h0, "busy after stop word");
	endtask : finishList
	task automatic testReset();
		ahb(1'b0, OFS_CONTROL, 32'h0);
		check(36'(rd), 36'(CONTROL_RST), "control at reset");
		check(36'(hresp), 36'h0, "okay response");
		ahb(1'b0, OFS_STATUS, 32'h0);
		check(36'(rd), 36'h0, "status at reset");
		ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
		ahb(1'b0, 8'h40, 32'h0);
		check(36'(rd), 36'h0, "unmapped read");
		$display("test reset done");
	endtask : testReset
	// device into memory: jump, block of 3, skip of 2, stop
	task automatic testToMemory();
		int w0;
		slow <= 1'b1;
		ahb(1'b1, OFS_CONTROL, ctl(CTL_EVLOCK));
		u_cld_mem_model.mem[8'h08] = cw(18'h0, 22'h20, 1'b0);
		u_cld_mem_model.mem[8'h20] = cw(18'h3FFFD, 22'h3F, 1'b0);
		u_cld_mem_model.mem[8'h21] = cw(18'h3FFFE, 22'h0, 1'b0);
		u_cld_mem_model.mem[8'h22] = 36'h0;
		u_cld_mem_model.mem[8'h3F] = 36'h0;
		u_cld_mem_model.mem[8'h43] = 36'h0;
		ctrlWriteData <= 36'h5_A5A5_A5A5;
		w0 = wrCount;
		startList(8'h04, 1'b0, 1'b1);
		finishList();
		check(36'(wrCount - w0), 36'h3, "words stored");
		for (int i = 64; i < 67; i++) check(u_cld_mem_model.mem[i], 36'h5_A5A5_A5A5, "word");
		check(u_cld_mem_model.mem[8'h3F], 36'h0, "word at stated address");
		check(u_cld_mem_model.mem[8'h43], 36'h0, "word past block");
		check(36'(evenCount), 36'h0, "even parity written");
		$display("test to memory done");
	endtask : testToMemory
	// memory to device, wide layout, prompt memory
	task automatic testToDevice();
		slow <= 1'b0;
		ahb(1'b1, OFS_CONTROL, ctl(CTL_WIDE));
		ahb(1'b0, OFS_CONTROL, 32'h0);
		check(36'(rd), 36'(ctl(CTL_WIDE)), "control readback");
		u_cld_mem_model.mem[8'h20] = cw(18'h3FFE, 22'h4F, 1'b1);
		u_cld_mem_model.mem[8'h21] = 36'h0;
		u_cld_mem_model.mem[8'h50] = 36'h1_2345_6789;
		u_cld_mem_model.mem[8'h51] = 36'hF_0000_0001;
		rdQ.delete();
		startList(8'h10, 1'b1, 1'b0);
		finishList();
		check(36'(rdQ.size()), 36'h2, "words to device");
		check(rdQ[0], 36'h1_2345_6789, "first word");
		check(rdQ[1], 36'hF_0000_0001, "second word");
		ahb(1'b1, OFS_CONTROL, 32'h0);
		$display("test to device done");
	endtask : testToDevice
	// halt on a bad word, flags, kept buffer, then clear
	task automatic parityCase(input logic [7:0] ia, input logic [1:0] flags);
		ahb(1'b1, OFS_CONTROL, ctl(CTL_MAINT) | ctl(CTL_PEHALT));
		badParity <= 1'b1;
		startList(ia, 1'b1, 1'b0);
		tick(30);
		ahb(1'b0, OFS_STATUS, 32'h0);
		check(36'(rd[3:2]), 36'(flags), "parity flags");
		check(36'(channelBusy), 36'h1, "halted");
		ahb(1'b0, OFS_BUFFER, 32'h0);
		if (flags[1]) check(36'(rd), 36'h1357_9BDF, "buffer kept");
		badParity <= 1'b0;
		ctrlDevicePulse <= 1'b0;
		ahb(1'b1, OFS_CONTROL, ctl(CTL_CLEAR));
		tick(2);
		ahb(1'b0, OFS_STATUS, 32'h0);
		check(36'(rd[3:1]), 36'h0, "status after clear");
	endtask : parityCase
	task automatic testParity();
		u_cld_mem_model.mem[8'h08] = cw(18'h3FFFF, 22'h3F, 1'b0);
		u_cld_mem_model.mem[8'h40] = 36'h0_1357_9BDF;
		u_cld_mem_model.mem[8'h48] = cw(18'h3FFFF, 22'h3F, 1'b0);
		parityCase(8'h24, 2'b01);
		parityCase(8'h04, 2'b10);
		$display("test parity done");
	endtask : testParity
	// local mode: single step, stop, timed clear
	task automatic testLocal();
		int a0;
		u_cld_mem_model.mem[8'h00] = cw(18'h3FFFE, 22'h2F, 1'b0);
		u_cld_mem_model.mem[8'h01] = cw(18'h0, 22'h01, 1'b0); // jump to itself
		ctrlRequest <= 4'hF;
		a0 = ackCount;
		ahb(1'b1, OFS_CONTROL, ctl(CTL_LOCAL) | ctl(CTL_SSTEP) | ctl(CTL_START));
		tick(40);
		check(36'(ackCount - a0), 36'h1, "one cycle per start");
		check(36'(ctrlGrant), 36'h0, "pins ignored");
		ctrlRequest <= 4'h0;
		ahb(1'b1, OFS_CONTROL, ctl(CTL_LOCAL) | ctl(CTL_SSTEP) | ctl(CTL_START));
		tick(40);
		check(36'(ackCount - a0), 36'h2, "second step");
		check(u_cld_mem_model.mem[8'h30], 36'h30, "simulated device word");
		ahb(1'b1, OFS_CONTROL, ctl(CTL_LOCAL) | ctl(CTL_SSTEP) | ctl(CTL_STOP));
		tick(4);
		ahb(1'b0, OFS_STATUS, 32'h0);
		check(36'(rd[8:6]), 36'(CLD_HALT), "halted by stop");
		ahb(1'b1, OFS_CONTROL, ctl(CTL_CLEAR));
		tick(4);
		check(36'(channelBusy), 36'h0, "cleared");
		ahb(1'b1, OFS_CONTROL, ctl(CTL_LOCAL) | ctl(CTL_DIR) | ctl(CTL_AUTOCLR) | ctl(CTL_START));
		tick(40);
		check(36'(channelBusy), 36'h1, "local run");
		tick(20);
		check(36'(channelBusy), 36'h0, "timed clear");
		$display("test local done");
	endtask : testLocal
	// main sequence
	initial begin
		rst = 1'b1;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		{ctrlRequest, ctrlDevicePulse, ctrlInitAddr, memToDev, ctrlWriteData} = '0;
		{slow, badParity} = 2'h0;
		failCount = 0;
		cmpCount = 0;
		tick(2);
		rst <= 1'b0;
		testReset();
		testToMemory();
		testToDevice();
		testParity();
		testLocal();
		testDone();
	end
endmodule : tb_cld_channel
